// >>> src/rcf_flags.sv
// Function
// - A non-power reset updates only the flag of its source.
// - Hardware returns a flag to inactive only on a power event.
// - Software may force flags active, no reset.
// - Stack overflow sets bit 7; power clears.
// - Stack underflow sets bit 6; power clears.
// - Bit 5 reads zero, writes ignored.
// - Watchdog reset clears bit 4.
// - External pin reset clears bit 3.
// - Reset instruction clears bit 2.
// - Power-on clears bit 1; software rearms.
// - Brown-out clears bit 0; software rearms.
// - Stack events set their flags only when enabled.
`default_nettype none
module rcf_flags (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire rcf_pkg::rcf_bus_req_t        busReq,
    input  wire rcf_pkg::rcf_events_t         events,
    input  wire logic                         stackResetEnable,
    output logic [rcf_pkg::FLAG_W-1:0]        rdData,
    output logic                              rdValid,
    output logic [rcf_pkg::FLAG_W-1:0]        flags
);
    import rcf_pkg::*;

    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] hwMask;
    logic [FLAG_W-1:0] hwValue;
    logic [FLAG_W-1:0] swImage;
    rcf_cause_t        causeCode;
    rcf_cause_t        lastCause_reg;
    logic [CNT_W-1:0]  eventCount_reg;
    logic              anyCause;
    logic              flagWrite;
    logic              powerEvent;

    if (FLAG_W != 8) begin : g_width_check
        $error("Flag register must be eight bits wide.");
    end

    rcf_cause_decode u_decode (
        .events           (events),
        .stackResetEnable (stackResetEnable),
        .hwMask           (hwMask),
        .hwValue          (hwValue),
        .causeCode        (causeCode),
        .anyCause         (anyCause)
    );

    rcf_bus_slave u_slave (
        .clk        (clk),
        .rst        (rst),
        .busReq     (busReq),
        .flags      (flags_reg),
        .lastCause  (lastCause_reg),
        .eventCount (eventCount_reg),
        .flagWrite  (flagWrite),
        .rdData     (rdData),
        .rdValid    (rdValid)
    );

    assign powerEvent = events.powerOn || events.brownOut;

    // A write only stores a value; it never feeds back into the cause logic.
    always_comb begin
        swImage = flagWrite ? busReq.wrData : flags_reg;
        flags_next = (swImage & ~hwMask) | (hwValue & hwMask);
        flags_next = flags_next & IMPL_MASK;
    end

    // Nothing but rst, a cause or a write moves a bit, so flags stay put otherwise.
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lastCause_reg <= CAUSE_NONE;
        end else if (anyCause) begin
            lastCause_reg <= causeCode;
        end
    end

    // The count saturates so a burst of resets cannot wrap back to a small figure.
    always_ff @(posedge clk) begin
        if (rst) begin
            eventCount_reg <= '0;
        end else if (anyCause && (eventCount_reg != '1)) begin
            eventCount_reg <= eventCount_reg + 8'h01;
        end
    end

    assign flags = flags_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_only_cause: assert property (
        anyCause && !flagWrite && !powerEvent
        |=> ((flags_reg ^ $past(flags_reg)) & ~$past(hwMask)) == 8'h00
    ) else $error("A flag outside the reset source changed.");

    a_no_release: assert property (
        !flagWrite && !powerEvent
        |=> ((flags_reg & ~$past(flags_reg) & 8'h1F) == 8'h00)
            && ((~flags_reg & $past(flags_reg) & 8'hC0) == 8'h00)
    ) else $error("Hardware returned a flag to its inactive state.");

    a_sw_force: assert property (
        flagWrite && !anyCause
        |=> flags_reg == ($past(busReq.wrData) & IMPL_MASK)
    ) else $error("Written flag value was not stored.");

    a_sw_no_cause: assert property (
        flagWrite && !anyCause
        |=> lastCause_reg == $past(lastCause_reg)
            && eventCount_reg == $past(eventCount_reg)
    ) else $error("A software write acted as a reset.");

    a_ovf_set: assert property (
        events.stackOvf && stackResetEnable && !powerEvent
        |=> flags_reg[BIT_STK_OVF]
    ) else $error("Stack overflow did not set its flag.");

    a_unf_set: assert property (
        events.stackUnf && stackResetEnable && !powerEvent
        |=> flags_reg[BIT_STK_UNF]
    ) else $error("Stack underflow did not set its flag.");

    a_stack_power: assert property (
        powerEvent |=> flags_reg[BIT_STK_OVF:BIT_STK_UNF] == 2'b00
    ) else $error("Stack flags not zero after a power event.");

    a_unimpl_zero: assert property (
        !flags_reg[BIT_UNIMPL] && !(rdValid && rdData[BIT_UNIMPL])
    ) else $error("Unimplemented bit read as one.");

    a_wdt_clear: assert property (
        events.watchdog && !powerEvent |=> !flags_reg[BIT_WDT]
    ) else $error("Watchdog reset did not clear its flag.");

    a_ext_clear: assert property (
        events.extPin && !powerEvent |=> !flags_reg[BIT_EXT]
    ) else $error("External pin reset did not clear its flag.");

    a_ri_clear: assert property (
        events.resetInstr && !powerEvent |=> !flags_reg[BIT_RI]
    ) else $error("Reset instruction did not clear its flag.");

    a_por_clear: assert property (
        events.powerOn
        |=> !flags_reg[BIT_POR] && flags_reg[BIT_WDT:BIT_RI] == 3'b111
            && flags_reg[BIT_BOR] == $past(flags_reg[BIT_BOR])
    ) else $error("Power-on reset image wrong.");

    a_bor_clear: assert property (
        events.brownOut && !events.powerOn
        |=> !flags_reg[BIT_BOR]
            && flags_reg[BIT_POR] == $past(flags_reg[BIT_POR])
    ) else $error("Brown-out reset image wrong.");

    a_stack_gate: assert property (
        !stackResetEnable && !flagWrite && !powerEvent
        |=> flags_reg[BIT_STK_OVF:BIT_STK_UNF]
            == $past(flags_reg[BIT_STK_OVF:BIT_STK_UNF])
    ) else $error("Stack flag moved while stack reset disabled.");

    a_hw_wins: assert property (
        flagWrite && anyCause
        |=> ((flags_reg ^ $past(hwValue)) & $past(hwMask) & IMPL_MASK) == 8'h00
    ) else $error("Software write beat the hardware update.");

    a_read_flags: assert property (
        busReq.rdStrobe && busReq.addr == OFF_FLAGS
        |=> rdValid && rdData == $past(flags_reg)
        ##1 rdData == 8'h00 || $past(busReq.rdStrobe)
    ) else $error("Flag read data wrong or late.");

    // Read data come from a register, so each read is held against the cycle of its strobe.
    a_read_cause: assert property (
        busReq.rdStrobe && busReq.addr == OFF_CAUSE
        |=> rdValid && rdData == {5'h00, $past(lastCause_reg)}
    ) else $error("Cause read data wrong or late.");

    a_read_count: assert property (
        busReq.rdStrobe && busReq.addr == OFF_COUNT
        |=> rdValid && rdData == $past(eventCount_reg)
    ) else $error("Count read data wrong or late.");

    a_read_unmapped: assert property (
        busReq.rdStrobe && busReq.addr != OFF_FLAGS
        && busReq.addr != OFF_CAUSE && busReq.addr != OFF_COUNT
        |=> rdValid && rdData == 8'h00
    ) else $error("Unmapped read returned data.");

    a_read_idle: assert property (
        !busReq.rdStrobe
        |=> !rdValid && rdData == 8'h00
    ) else $error("Read data stood without a read strobe.");

    // An rst pulse leaves the power-on image, so software always sees a clean record.
    a_reset_image: assert property (
        $past(rst)
        |-> flags_reg == FLAGS_RST && lastCause_reg == CAUSE_NONE
            && eventCount_reg == 8'h00
    ) else $error("Register state wrong after reset.");

    a_write_other: assert property (
        busReq.wrStrobe && busReq.addr != OFF_FLAGS && !anyCause
        |=> flags_reg == $past(flags_reg)
    ) else $error("Write to another offset changed the flags.");

    a_hw_image: assert property (
        anyCause && !powerEvent
        |-> (hwValue & ~hwMask) == 8'h00
            && (hwValue & 8'h1F) == 8'h00
    ) else $error("Cause logic tried to set an active-low flag.");

    a_multi_cause: assert property (
        events.watchdog && events.extPin && events.resetInstr && !powerEvent
        |=> flags_reg[BIT_WDT:BIT_RI] == 3'b000
    ) else $error("Coinciding causes did not each clear their flag.");

    // The cause record only moves on a real cause, never on a software write.
    a_cause_code: assert property (
        anyCause
        |=> lastCause_reg == $past(causeCode)
    ) else $error("Last cause code not recorded.");

    a_cause_hold: assert property (
        !anyCause
        |=> lastCause_reg == $past(lastCause_reg)
    ) else $error("Last cause code moved without a cause.");

    a_power_cause: assert property (
        events.powerOn
        |=> lastCause_reg == CAUSE_POR
    ) else $error("Power-on not recorded as the cause.");

    a_bor_cause: assert property (
        events.brownOut && !events.powerOn
        |=> lastCause_reg == CAUSE_BOR
    ) else $error("Brown-out not recorded as the cause.");

    a_wdt_cause: assert property (
        events.watchdog && !events.extPin && !events.resetInstr
        && !events.stackOvf && !events.stackUnf && !powerEvent
        |=> lastCause_reg == CAUSE_WDT
    ) else $error("Watchdog not recorded as the cause.");

    a_unf_cause: assert property (
        events.stackUnf && stackResetEnable && !powerEvent
        |=> lastCause_reg == CAUSE_UNF
    ) else $error("Stack underflow not recorded as the cause.");

    a_stack_cause: assert property (
        (events.stackOvf || events.stackUnf) && !stackResetEnable
        && !events.powerOn && !events.brownOut && !events.watchdog
        && !events.extPin && !events.resetInstr
        |=> eventCount_reg == $past(eventCount_reg)
    ) else $error("Gated stack event counted as a reset.");

    // The count is a diagnostic aid; it saturates rather than wrap to a misleading value.
    a_count_step: assert property (
        anyCause && eventCount_reg != 8'hFF
        |=> eventCount_reg == $past(eventCount_reg) + 8'h01
    ) else $error("Reset count did not advance.");

    a_count_hold: assert property (
        !anyCause
        |=> eventCount_reg == $past(eventCount_reg)
    ) else $error("Reset count moved without a cause.");

    a_count_sat: assert property (
        eventCount_reg == 8'hFF
        |=> eventCount_reg == 8'hFF
    ) else $error("Reset count wrapped past its ceiling.");

    c_wdt_rearm: cover property (
        events.watchdog ##[1:8] flagWrite && busReq.wrData[BIT_WDT]
    );

    c_collision: cover property (
        flagWrite && anyCause
    );

    c_por_then_bor: cover property (
        events.powerOn ##[1:20] events.brownOut
    );

    c_stack_gated: cover property (
        events.stackOvf && !stackResetEnable
    );

    c_count_read: cover property (
        busReq.rdStrobe && busReq.addr == OFF_COUNT
    );
endmodule // rcf_flags
`default_nettype wire

// >>> src/rcf_pkg.sv
`default_nettype none
package rcf_pkg;
    localparam int FLAG_W = 8;
    localparam int ADDR_W = 4;
    localparam int CNT_W  = 8;

    localparam int BIT_STK_OVF = 7;
    localparam int BIT_STK_UNF = 6;
    localparam int BIT_UNIMPL  = 5;
    localparam int BIT_WDT     = 4;
    localparam int BIT_EXT     = 3;
    localparam int BIT_RI      = 2;
    localparam int BIT_POR     = 1;
    localparam int BIT_BOR     = 0;

    localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h1C;
    localparam logic [FLAG_W-1:0] IMPL_MASK = 8'hDF;
    localparam logic [FLAG_W-1:0] PWR_IMAGE = 8'h1C;
    localparam logic [FLAG_W-1:0] POR_MASK  = 8'hFE;
    localparam logic [FLAG_W-1:0] BOR_MASK  = 8'hFD;

    localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CAUSE = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h2;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_POR  = 3'b001,
        CAUSE_BOR  = 3'b010,
        CAUSE_WDT  = 3'b011,
        CAUSE_EXT  = 3'b100,
        CAUSE_RI   = 3'b101,
        CAUSE_OVF  = 3'b110,
        CAUSE_UNF  = 3'b111
    } rcf_cause_t;

    typedef struct packed {
        logic powerOn;
        logic brownOut;
        logic watchdog;
        logic extPin;
        logic resetInstr;
        logic stackOvf;
        logic stackUnf;
    } rcf_events_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [FLAG_W-1:0] wrData;
        logic              wrStrobe;
        logic              rdStrobe;
    } rcf_bus_req_t;

    function automatic logic [FLAG_W-1:0] rcf_bit(input int pos);
        rcf_bit = 8'h01 << pos;
    endfunction
endpackage
`default_nettype wire

// >>> src/rcf_cause_decode.sv
`default_nettype none
module rcf_cause_decode (
    input  wire rcf_pkg::rcf_events_t       events,
    input  wire logic                       stackResetEnable,
    output logic [rcf_pkg::FLAG_W-1:0]      hwMask,
    output logic [rcf_pkg::FLAG_W-1:0]      hwValue,
    output rcf_pkg::rcf_cause_t             causeCode,
    output logic                            anyCause
);
    import rcf_pkg::*;

    // Power events rebuild all bits but the other power flag; other causes touch only their own bit.
    always_comb begin
        hwMask    = '0;
        hwValue   = '0;
        causeCode = CAUSE_NONE;
        if (events.powerOn) begin
            hwMask    = POR_MASK;
            hwValue   = PWR_IMAGE;
            causeCode = CAUSE_POR;
        end else if (events.brownOut) begin
            hwMask    = BOR_MASK;
            hwValue   = PWR_IMAGE;
            causeCode = CAUSE_BOR;
        end else begin
            if (events.watchdog) begin
                hwMask    = hwMask | rcf_bit(BIT_WDT);
                causeCode = CAUSE_WDT;
            end
            if (events.extPin) begin
                hwMask    = hwMask | rcf_bit(BIT_EXT);
                causeCode = CAUSE_EXT;
            end
            if (events.resetInstr) begin
                hwMask    = hwMask | rcf_bit(BIT_RI);
                causeCode = CAUSE_RI;
            end
            if (stackResetEnable && events.stackOvf) begin
                hwMask    = hwMask | rcf_bit(BIT_STK_OVF);
                hwValue   = hwValue | rcf_bit(BIT_STK_OVF);
                causeCode = CAUSE_OVF;
            end
            if (stackResetEnable && events.stackUnf) begin
                hwMask    = hwMask | rcf_bit(BIT_STK_UNF);
                hwValue   = hwValue | rcf_bit(BIT_STK_UNF);
                causeCode = CAUSE_UNF;
            end
        end
    end

    assign anyCause = (causeCode != CAUSE_NONE);
endmodule // rcf_cause_decode
`default_nettype wire

// >>> src/rcf_bus_slave.sv
`default_nettype none
module rcf_bus_slave (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire rcf_pkg::rcf_bus_req_t        busReq,
    input  wire logic [rcf_pkg::FLAG_W-1:0]   flags,
    input  wire rcf_pkg::rcf_cause_t          lastCause,
    input  wire logic [rcf_pkg::CNT_W-1:0]    eventCount,
    output logic                              flagWrite,
    output logic [rcf_pkg::FLAG_W-1:0]        rdData,
    output logic                              rdValid
);
    import rcf_pkg::*;

    logic [FLAG_W-1:0] rdData_reg;
    logic              rdValid_reg;

    assign flagWrite = busReq.wrStrobe && (busReq.addr == OFF_FLAGS);

    // Unmapped offsets read as zero so software never sees stale data.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_reg <= 8'h00;
        end else if (!busReq.rdStrobe) begin
            rdData_reg <= 8'h00;
        end else if (busReq.addr == OFF_FLAGS) begin
            rdData_reg <= flags & IMPL_MASK;
        end else if (busReq.addr == OFF_CAUSE) begin
            rdData_reg <= {5'h00, lastCause};
        end else if (busReq.addr == OFF_COUNT) begin
            rdData_reg <= eventCount;
        end else begin
            rdData_reg <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= busReq.rdStrobe;
        end
    end

    assign rdData  = rdData_reg;
    assign rdValid = rdValid_reg;
endmodule // rcf_bus_slave
`default_nettype wire

// >>> dv/rcf_flags_tb_top.sv
`default_nettype none
module rcf_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rcf_pkg::*;

    logic                clk;
    logic                rst;
    rcf_bus_req_t        busReq;
    rcf_events_t         events;
    logic                stackResetEnable;
    logic [FLAG_W-1:0]   rdData;
    logic                rdValid;
    logic [FLAG_W-1:0]   flags;
    logic [FLAG_W-1:0]   exp;
    int                  n_fail;
    int                  compares;
    int                  cycles;

    // Event patterns, msb first: powerOn, brownOut, watchdog, extPin, resetInstr, ovf, unf.
    localparam logic [6:0] EV_POR = 7'h40;
    localparam logic [6:0] EV_BOR = 7'h20;
    localparam logic [6:0] EV_WDT = 7'h10;
    localparam logic [6:0] EV_EXT = 7'h08;
    localparam logic [6:0] EV_RI  = 7'h04;
    localparam logic [6:0] EV_OVF = 7'h02;
    localparam logic [6:0] EV_UNF = 7'h01;

    rcf_flags dut_u (
        .clk              (clk),
        .rst              (rst),
        .busReq           (busReq),
        .events           (events),
        .stackResetEnable (stackResetEnable),
        .rdData           (rdData),
        .rdValid          (rdValid),
        .flags            (flags)
    );

    always #10 clk = ~clk;

    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cut a hang short; the whole sequence needs well under a few hundred cycles.
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
        compares = compares + 1;
        if (seen !== want) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", name, want, seen);
        end
    endtask

    // One bus cycle plus event pulse, both taken at the same edge; returns once settled.
    task automatic drive(input logic w, input logic r, input logic [3:0] a,
                         input logic [7:0] d, input logic [6:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wrData: d, wrStrobe: w, rdStrobe: r};
        events <= rcf_events_t'(e);
        @(posedge clk);
        busReq <= '0;
        events <= '0;
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, a, d, 7'h00);
        chk("flags after write", flags, exp);
    endtask

    // Read data stand for exactly one cycle, then drop back to zero.
    task automatic rd(input logic [3:0] a, input logic [7:0] want);
        drive(1'b0, 1'b1, a, 8'h00, 7'h00);
        chk("rdValid", {7'h00, rdValid}, 8'h01);
        chk("rdData", rdData, want);
        @(posedge clk);
        #1;
        chk("rdValid low", {7'h00, rdValid}, 8'h00);
    endtask

    task automatic ev(input logic [6:0] e);
        drive(1'b0, 1'b0, 4'h0, 8'h00, e);
        chk("flags after event", flags, exp);
    endtask

    task automatic t_write_readback();
        exp = 8'hDF;
        wr(OFF_FLAGS, 8'hFF);
        rd(OFF_FLAGS, 8'hDF);
        exp = 8'h1F;
        wr(OFF_FLAGS, 8'h1F);
        rd(4'h5, 8'h00);
        wr(4'h5, 8'h00);
    endtask

    task automatic t_stack();
        @(posedge clk);
        stackResetEnable <= 1'b0;
        ev(EV_OVF);
        ev(EV_UNF);
        @(posedge clk);
        stackResetEnable <= 1'b1;
        exp = 8'h9F;
        ev(EV_OVF);
        exp = 8'hDF;
        ev(EV_UNF);
    endtask

    task automatic t_active_low();
        exp = 8'hCF;
        ev(EV_WDT);
        exp = 8'hC7;
        ev(EV_EXT);
        exp = 8'hC3;
        ev(EV_RI);
        ev(EV_WDT);
        rd(OFF_FLAGS, 8'hC3);
    endtask

    // The watchdog bit must win against a same-cycle write; other bits but bit 5 take the write.
    task automatic t_collision();
        drive(1'b1, 1'b0, OFF_FLAGS, 8'hFF, EV_WDT);
        chk("flags write vs event", flags, 8'hCF);
    endtask

    task automatic t_power();
        exp = 8'h1D;
        ev(EV_POR);
        exp = 8'hDF;
        wr(OFF_FLAGS, 8'hFF);
        exp = 8'h1E;
        ev(EV_BOR);
        exp = 8'h1F;
        wr(OFF_FLAGS, 8'h1F);
        rd(OFF_CAUSE, {5'h00, CAUSE_BOR});
        rd(OFF_COUNT, 8'h09);
    endtask

    // A second reset in mid-run must bring back the power-on image and clear the record.
    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("flags after reset", flags, FLAGS_RST);
        rd(OFF_CAUSE, 8'h00);
        rd(OFF_COUNT, 8'h00);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        busReq = '0;
        events = '0;
        stackResetEnable = 1'b0;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("flags reset", flags, FLAGS_RST);
        rd(OFF_FLAGS, 8'h1C);
        t_write_readback();
        t_stack();
        t_active_low();
        t_collision();
        t_power();
        t_reset();
        tally_and_finish();
    end
endmodule // rcf_flags_tb_top
`default_nettype wire
